// ===== rtl/bsd_pkg.sv
// Purpose: constants and types shared by the backlight saver and dimmer
// Assumes: one 25 MHz clock, APB slave, 32-bit aligned registers
// Notes:
package bsd_pkg;

	// clock and time base
	localparam int CLK_PERIOD_NS = 40;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOCKOUT_MS = 1000;
	localparam int LOCKOUT_TICKS = (LOCKOUT_MS * 1000000 + TICK_PERIOD_NS - 1) / TICK_PERIOD_NS;
	localparam int PWM_STEP_CYCLES = 10;
	localparam int PWM_STEPS = 100;

	// widths
	localparam int ADDR_W = 8;
	localparam int LEVEL_W = 7;
	localparam int TIMEOUT_W = 24;
	localparam int LOCK_W = 16;
	localparam int SWALLOW_W = 16;

	// register offsets (byte addresses)
	localparam logic [7:0] OFS_LEVEL = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_TIMEOUT = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_SWALLOW = 8'h10;
	localparam logic [7:0] OFS_IDLE = 8'h14;

	// field positions
	localparam int COIL_BIT = 16;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_WAKE_BIT = 1;

	// values after reset, and the full level that writes clamp to
	localparam logic [6:0] LEVEL_RST = 7'h64;
	localparam logic [6:0] LEVEL_FULL = 7'h64;
	localparam logic CTRL_EN_RST = 1'b0;
	localparam logic [23:0] TIMEOUT_RST = 24'h0493E0;

	typedef enum logic [1:0] {
		ST_LIT = 2'b00,
		ST_DARK = 2'b01,
		ST_LOCK = 2'b10
	} bsd_state_t;

endpackage : bsd_pkg

// ===== rtl/bsd_timebase_if.sv
// Purpose: carries the slow enable pulses from the divider to their users
// Assumes: each pulse is one pclk cycle wide when its count is above one
// Notes: src drives, snk reads
`timescale 1ns/1ps
interface bsd_timebase_if;
	logic ms_tick;
	logic pwm_step;
	modport src (output ms_tick, output pwm_step);
	modport snk (input ms_tick, input pwm_step);
endinterface : bsd_timebase_if

// ===== rtl/bsd_tick_div.sv
// Purpose: divides pclk into a millisecond tick and a pwm step enable
// Assumes: counts of at least one cycle
// Notes: both outputs come from flip-flops; each is a single-cycle pulse when its count is above one, and stays high at a count of one
`timescale 1ns/1ps
module bsd_tick_div #(
	parameter int TICK_CYCLES = bsd_pkg::TICK_CYCLES,
	parameter int STEP_CYCLES = bsd_pkg::PWM_STEP_CYCLES
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// pulses out
	bsd_timebase_if.src tb
);
	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam int SW = $clog2(STEP_CYCLES + 1);
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
	localparam logic [SW-1:0] STEP_LAST = SW'(STEP_CYCLES - 1);

	logic [TW-1:0] tick_cnt_reg;
	logic [SW-1:0] step_cnt_reg;
	logic tick_reg;
	logic step_reg;

	wire logic tick_wrap_w = (tick_cnt_reg == TICK_LAST);
	wire logic step_wrap_w = (step_cnt_reg == STEP_LAST);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_reg <= '0;
			step_cnt_reg <= '0;
			tick_reg <= 1'b0;
			step_reg <= 1'b0;
		end else begin
			tick_cnt_reg <= tick_wrap_w ? '0 : tick_cnt_reg + TW'(1);
			step_cnt_reg <= step_wrap_w ? '0 : step_cnt_reg + SW'(1);
			tick_reg <= tick_wrap_w;
			step_reg <= step_wrap_w;
		end
	end

	assign tb.ms_tick = tick_reg;
	assign tb.pwm_step = step_reg;
endmodule : bsd_tick_div

// ===== rtl/bsd_pwm.sv
// Purpose: turns a 0..100 level into a backlight pwm waveform
// Assumes: level above 99 means always on, 0 means always off
// Notes: one pwm period is 100 step enables
`timescale 1ns/1ps
module bsd_pwm #(
	parameter int LEVEL_W = bsd_pkg::LEVEL_W
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// time base
	bsd_timebase_if.snk tb,
	// level and output
	input wire logic [LEVEL_W-1:0] level,
	output logic pwm_out
);
	localparam logic [LEVEL_W-1:0] STEP_LAST = LEVEL_W'(bsd_pkg::PWM_STEPS - 1);

	logic [LEVEL_W-1:0] phase_reg;
	logic out_reg;

	wire logic wrap_w = (phase_reg == STEP_LAST);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_reg <= '0;
			out_reg <= 1'b0;
		end else begin
			if (tb.pwm_step) begin
				phase_reg <= wrap_w ? '0 : phase_reg + LEVEL_W'(1);
			end
			// level is compared every cycle so a change shows one pclk cycle later, without waiting for a step enable
			out_reg <= (phase_reg < level);
		end
	end

	assign pwm_out = out_reg;
endmodule : bsd_pwm

// ===== rtl/bsd_backlight_saver.sv
// Purpose: backlight screen saver, wake lockout and brightness control
// Assumes: touch and key inputs are levels synchronous to pclk
// Notes: apb slave answers in the second access cycle
`timescale 1ns/1ps
module bsd_backlight_saver #(
	parameter int NUM_KEYS = 4,
	parameter int TICK_CYCLES = bsd_pkg::TICK_CYCLES,
	parameter int LOCKOUT_TICKS = bsd_pkg::LOCKOUT_TICKS,
	parameter int STEP_CYCLES = bsd_pkg::PWM_STEP_CYCLES
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// operator inputs
	input wire logic touch_in,
	input wire logic [NUM_KEYS-1:0] key_in,
	// inputs passed on to the application
	output logic touch_out,
	output logic [NUM_KEYS-1:0] key_out,
	// backlight
	output logic backlight_pwm,
	output logic saver_dark,
	output logic wake_lockout
);
	localparam int NCH = NUM_KEYS + 1;
	localparam int LW = bsd_pkg::LEVEL_W;
	localparam int TW = bsd_pkg::TIMEOUT_W;
	localparam int KW = bsd_pkg::LOCK_W;
	localparam int CW = bsd_pkg::SWALLOW_W;
	localparam logic [KW-1:0] LOCK_LAST = KW'(LOCKOUT_TICKS - 1);
	localparam logic [TW-1:0] IDLE_MAX = '1;
	localparam logic [CW-1:0] SWALLOW_MAX = '1;

	// register state
	logic [LW-1:0] level_reg;
	logic coil_last_reg;
	logic en_reg;
	logic [TW-1:0] timeout_reg;
	logic [CW-1:0] swallow_reg;
	logic [CW-1:0] swallow_next;

	// saver state
	bsd_pkg::bsd_state_t state_reg;
	bsd_pkg::bsd_state_t state_next;
	logic [TW-1:0] idle_reg;
	logic [TW-1:0] idle_next;
	logic [KW-1:0] lock_cnt_reg;
	logic [KW-1:0] lock_cnt_next;
	logic dark_reg;
	logic lock_reg;

	// channel state
	logic [NCH-1:0] prev_reg;
	logic [NCH-1:0] blk_reg;
	logic [NCH-1:0] pass_reg;
	logic [NCH-1:0] rise_w;
	logic [NCH-1:0] blk_next_w;
	logic [NCH-1:0] pass_w;

	// bus answer
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;

	bsd_timebase_if tb ();

	bsd_tick_div #(
		.TICK_CYCLES(TICK_CYCLES),
		.STEP_CYCLES(STEP_CYCLES)
	) u_div (
		.pclk(pclk),
		.presetn(presetn),
		.tb(tb.src)
	);

	// apb decode
	// one wait state always: capture on the first access edge, answer on the next
	wire logic capture_w = psel & penable & ~pready_reg;
	wire logic fire_w = psel & penable & pready_reg;
	wire logic wr_w = fire_w & pwrite;
	wire logic hit_level_w = (paddr == bsd_pkg::OFS_LEVEL);
	wire logic hit_ctrl_w = (paddr == bsd_pkg::OFS_CTRL);
	wire logic hit_timeout_w = (paddr == bsd_pkg::OFS_TIMEOUT);
	wire logic hit_status_w = (paddr == bsd_pkg::OFS_STATUS);
	wire logic hit_swallow_w = (paddr == bsd_pkg::OFS_SWALLOW);
	wire logic hit_idle_w = (paddr == bsd_pkg::OFS_IDLE);
	wire logic mapped_w = hit_level_w | hit_ctrl_w | hit_timeout_w | hit_status_w
		| hit_swallow_w | hit_idle_w;

	// write strobes
	wire logic lvl_wr_w = wr_w & hit_level_w;
	wire logic ctrl_wr_w = wr_w & hit_ctrl_w;
	wire logic tmo_wr_w = wr_w & hit_timeout_w;
	wire logic swl_clr_w = wr_w & hit_swallow_w;
	wire logic sw_wake_w = ctrl_wr_w & pwdata[bsd_pkg::CTRL_WAKE_BIT];

	// out-of-range levels clamp to full so a bad write never blanks the screen
	wire logic lvl_over_w = (pwdata[15:0] > {9'h000, bsd_pkg::LEVEL_FULL});
	wire logic [LW-1:0] lvl_in_w = lvl_over_w ? bsd_pkg::LEVEL_FULL : pwdata[LW-1:0];
	// only a 0 to 1 change of the coil counts, so holding it at 1 does nothing
	wire logic coil_rise_w = lvl_wr_w & pwdata[bsd_pkg::COIL_BIT] & ~coil_last_reg;

	// state decode
	wire logic lit_w = (state_reg == bsd_pkg::ST_LIT);
	wire logic is_dark_w = (state_reg == bsd_pkg::ST_DARK);
	wire logic is_lock_w = (state_reg == bsd_pkg::ST_LOCK);
	// bit 0 is the touch screen, the function keys follow
	wire logic [NCH-1:0] chan_w = {key_in, touch_in};

	// per-channel wake, swallow and pass-on
	generate
		for (genvar i = 0; i < NCH; i++) begin : g_ch
			assign rise_w[i] = chan_w[i] & ~prev_reg[i];
			// a channel pressed while not lit stays blocked until released
			assign blk_next_w[i] = chan_w[i] & (~lit_w | blk_reg[i]);
			assign pass_w[i] = chan_w[i] & lit_w & ~blk_reg[i];
		end
	endgenerate

	wire logic any_rise_w = |rise_w;
	wire logic accepted_w = |(rise_w & pass_w);
	wire logic swallowed_w = |(rise_w & ~pass_w);
	wire logic restart_w = accepted_w | coil_rise_w;

	// timeout: a restart in the same cycle keeps the screen lit
	wire logic timeout_hit_w = en_reg & (timeout_reg != '0) & (idle_reg >= timeout_reg)
		& ~restart_w;
	wire logic lock_done_w = is_lock_w & tb.ms_tick & (lock_cnt_reg == LOCK_LAST);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			bsd_pkg::ST_LIT: begin
				if (timeout_hit_w) begin
					state_next = bsd_pkg::ST_DARK;
				end
			end
			bsd_pkg::ST_DARK: begin
				if (~en_reg | sw_wake_w) begin
					state_next = bsd_pkg::ST_LIT;
				end else if (any_rise_w) begin
					state_next = bsd_pkg::ST_LOCK;
				end
			end
			bsd_pkg::ST_LOCK: begin
				if (lock_done_w) begin
					state_next = bsd_pkg::ST_LIT;
				end
			end
			default: begin
				state_next = bsd_pkg::ST_LIT;
			end
		endcase
	end

	// idle counter only runs while lit and saturates instead of wrapping
	assign idle_next = (restart_w | ~lit_w) ? '0
		: (tb.ms_tick & (idle_reg != IDLE_MAX)) ? idle_reg + TW'(1)
		: idle_reg;
	// the first tick of the lockout is partial, hence approximately one second
	assign lock_cnt_next = ~is_lock_w ? '0
		: tb.ms_tick ? lock_cnt_reg + KW'(1)
		: lock_cnt_reg;
	// a swallowed event in the clearing cycle still counts, except when the old count sits at SWALLOW_MAX
	assign swallow_next = (swl_clr_w ? '0 : swallow_reg)
		+ CW'(swallowed_w & (swallow_reg != SWALLOW_MAX));

	// read mux
	wire logic [31:0] rd_level_w = {25'h0000000, level_reg};
	wire logic [31:0] rd_ctrl_w = {31'h00000000, en_reg};
	wire logic [31:0] rd_timeout_w = {8'h00, timeout_reg};
	wire logic [31:0] rd_status_w = {28'h0000000, en_reg, lock_reg, dark_reg, lit_w};
	wire logic [31:0] rd_swallow_w = {16'h0000, swallow_reg};
	wire logic [31:0] rd_idle_w = {8'h00, idle_reg};
	wire logic [31:0] rd_data_w = hit_level_w ? rd_level_w
		: hit_ctrl_w ? rd_ctrl_w
		: hit_timeout_w ? rd_timeout_w
		: hit_status_w ? rd_status_w
		: hit_swallow_w ? rd_swallow_w
		: hit_idle_w ? rd_idle_w
		: 32'h00000000;

	// the saver forces the level to zero; otherwise the register drives it
	wire logic [LW-1:0] eff_level_w = dark_reg ? '0 : level_reg;

	bsd_pwm #(
		.LEVEL_W(LW)
	) u_pwm (
		.pclk(pclk),
		.presetn(presetn),
		.tb(tb.snk),
		.level(eff_level_w),
		.pwm_out(backlight_pwm)
	);

	// apb answer: one wait state so read data comes from a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end else begin
			pready_reg <= capture_w;
			// misaligned or unknown addresses answer with an error and have no effect
			pslverr_reg <= capture_w & ~mapped_w;
			if (capture_w) begin
				prdata_reg <= pwrite ? 32'h00000000 : rd_data_w;
			end
		end
	end

	// software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_reg <= bsd_pkg::LEVEL_RST;
			coil_last_reg <= 1'b0;
			en_reg <= bsd_pkg::CTRL_EN_RST;
			timeout_reg <= bsd_pkg::TIMEOUT_RST;
		end else begin
			if (lvl_wr_w) begin
				level_reg <= lvl_in_w;
				coil_last_reg <= pwdata[bsd_pkg::COIL_BIT];
			end
			if (ctrl_wr_w) begin
				en_reg <= pwdata[bsd_pkg::CTRL_EN_BIT];
			end
			if (tmo_wr_w) begin
				timeout_reg <= pwdata[TW-1:0];
			end
		end
	end

	// saver state; the status flags are registered copies of the next state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= bsd_pkg::ST_LIT;
			dark_reg <= 1'b0;
			lock_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			dark_reg <= (state_next == bsd_pkg::ST_DARK);
			lock_reg <= (state_next == bsd_pkg::ST_LOCK);
		end
	end

	// idle counter in ms ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_reg <= '0;
		end else begin
			idle_reg <= idle_next;
		end
	end

	// lockout counter in ms ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_cnt_reg <= '0;
		end else begin
			lock_cnt_reg <= lock_cnt_next;
		end
	end

	// swallowed event counter, kept for diagnostics only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			swallow_reg <= '0;
		end else begin
			swallow_reg <= swallow_next;
		end
	end

	// channel flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_reg <= '0;
			blk_reg <= '0;
			pass_reg <= '0;
		end else begin
			prev_reg <= chan_w;
			blk_reg <= blk_next_w;
			pass_reg <= pass_w;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign touch_out = pass_reg[0];
	assign key_out = pass_reg[NCH-1:1];
	assign saver_dark = dark_reg;
	assign wake_lockout = lock_reg;
endmodule : bsd_backlight_saver

// ===== testbench/bsd_saver_monitor.sv
// Purpose: concurrent checks on the saver ports
// Assumes: bound to bsd_backlight_saver
// Notes: level is tracked from completed apb writes
`timescale 1ns/1ps
module bsd_saver_monitor #(
	parameter int TICK_CYCLES = 4,
	parameter int LOCKOUT_TICKS = 3
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	// operator and backlight
	input wire logic touch_in,
	input wire logic touch_out,
	input wire logic backlight_pwm,
	input wire logic saver_dark,
	input wire logic wake_lockout
);
	// free-running tick gives up to one tick of slack
	localparam int LO_MIN = (LOCKOUT_TICKS - 1) * TICK_CYCLES;
	localparam int LO_MAX = LOCKOUT_TICKS * TICK_CYCLES + 2;
	logic [6:0] lvl_reg;
	int lk_reg;
	wire logic lvl_wr = psel && penable && pready && pwrite && paddr == 8'h00;
	wire logic [6:0] lvl_next = pwdata[15:0] > 16'h0064 ? 7'h64 : pwdata[6:0];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvl_reg <= 7'h64;
			lk_reg <= 0;
		end else begin
			lvl_reg <= lvl_wr ? lvl_next : lvl_reg;
			lk_reg <= wake_lockout ? lk_reg + 1 : 0;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_dark_off;
		saver_dark [*2] |-> !backlight_pwm;
	endproperty
	a_dark_off: assert property (p_dark_off) else $error("lit while dark");
	property p_wake;
		saver_dark && $rose(touch_in) |=> !saver_dark && wake_lockout;
	endproperty
	a_wake: assert property (p_wake) else $error("touch did not wake");
	property p_swallow;
		saver_dark && $rose(touch_in) |=> !touch_out;
	endproperty
	a_swallow: assert property (p_swallow) else $error("wake touch passed on");
	property p_lock_block;
		wake_lockout && $rose(touch_in) |=> !touch_out;
	endproperty
	a_lock_block: assert property (p_lock_block) else $error("touch passed in lockout");
	property p_lock_len;
		$fell(wake_lockout) |-> lk_reg >= LO_MIN && lk_reg <= LO_MAX;
	endproperty
	a_lock_len: assert property (p_lock_len) else $error("lockout length wrong");
	property p_pass;
		!saver_dark && !wake_lockout && $rose(touch_in) |=> touch_out;
	endproperty
	a_pass: assert property (p_pass) else $error("touch not passed on");
	property p_full;
		(lvl_reg == 7'h64 && !saver_dark) [*3] |-> backlight_pwm;
	endproperty
	a_full: assert property (p_full) else $error("full level not on");
	property p_zero;
		(lvl_reg == 7'h00) [*3] |-> !backlight_pwm;
	endproperty
	a_zero: assert property (p_zero) else $error("zero level not off");
endmodule : bsd_saver_monitor

bind bsd_backlight_saver bsd_saver_monitor #(
	.TICK_CYCLES(TICK_CYCLES),
	.LOCKOUT_TICKS(LOCKOUT_TICKS)
) u_bsd_saver_monitor (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.pready(pready),
	.paddr(paddr),
	.pwdata(pwdata),
	.touch_in(touch_in),
	.touch_out(touch_out),
	.backlight_pwm(backlight_pwm),
	.saver_dark(saver_dark),
	.wake_lockout(wake_lockout)
);

// ===== testbench/bsd_operator_model.sv
// Purpose: touch screen and function keys in front of the saver
// Assumes: levels change just after a rising edge
// Notes: idx below zero selects the touch screen
`timescale 1ns/1ps
module bsd_operator_model #(
	parameter int NUM_KEYS = 4
) (
	// clock
	input wire logic pclk,
	// operator levels
	output logic touch_in,
	output logic [NUM_KEYS-1:0] key_in
);
	initial begin
		touch_in = 1'b0;
		key_in = '0;
	end
	task automatic press(input int idx, input logic lvl);
		@(posedge pclk);
		if (idx < 0) begin
			touch_in <= lvl;
		end else begin
			key_in[idx] <= lvl;
		end
	endtask : press
endmodule : bsd_operator_model

// ===== testbench/bsd_backlight_saver_test.sv
// Purpose: self-checking bench for the backlight saver
// Assumes: shortened tick 4, lockout 3 ticks, pwm step 1
// Notes: register cases run from a table
`timescale 1ns/1ps
module bsd_backlight_saver_test;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} bsd_row_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, touch_in, touch_out;
	logic backlight_pwm, saver_dark, wake_lockout, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0] key_in, key_out;
	int n_mismatch = 0;
	int compares = 0;
	int n;
	bsd_row_t rows [7] = '{'{0, 8'h08, 0, 32'h000493E0, 0}, '{0, 8'h04, 0, 0, 0},
		'{1, 8'h00, 32'h000000C8, 0, 0}, '{0, 8'h00, 0, 32'h00000064, 0},
		'{1, 8'h00, 32'h00010000, 0, 0}, '{0, 8'h00, 0, 0, 0}, '{0, 8'h18, 0, 0, 1}};
	bsd_backlight_saver #(.NUM_KEYS(4), .TICK_CYCLES(4), .LOCKOUT_TICKS(3), .STEP_CYCLES(1))
	u_bsd_backlight_saver (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .touch_in(touch_in), .key_in(key_in), .touch_out(touch_out),
		.key_out(key_out), .backlight_pwm(backlight_pwm), .saver_dark(saver_dark),
		.wake_lockout(wake_lockout));
	bsd_operator_model #(.NUM_KEYS(4)) u_bsd_operator_model (.pclk(pclk),
		.touch_in(touch_in), .key_in(key_in));
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		compares++;
		if (g !== x) begin
			n_mismatch++;
			$display("mismatch t=%0t got %h exp %h", $time, g, x);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no cycle limit here: only the watchdog ends a hung transfer
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic tally_and_finish;
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (5) @(posedge pclk);
		chk({pready, backlight_pwm, saver_dark}, 0);
		presetn <= 1'b1;
		$display("test reset done");
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			chk({e, rows[i].w ? rows[i].x : r}, {rows[i].e, rows[i].x});
		end
		$display("test registers done");
		// idle has run long since reset, so restart it before the short timeout applies
		apb(1, 8'h00, 32'h00000064);
		apb(1, 8'h04, 32'h00000001);
		apb(1, 8'h00, 32'h00010064);
		apb(1, 8'h08, 32'h00000004);
		// keep-awake pulses must come faster than the timeout
		for (n = 0; n < 6; n++) begin
			apb(1, 8'h00, 32'h00000064);
			apb(1, 8'h00, 32'h00010064);
			chk(saver_dark, 0);
			chk(backlight_pwm, 1);
		end
		for (n = 0; n < 200 && saver_dark !== 1'b1; n++) @(posedge pclk);
		chk(saver_dark, 1);
		repeat (2) @(posedge pclk);
		chk(backlight_pwm, 0);
		u_bsd_operator_model.press(-1, 1);
		repeat (2) @(posedge pclk);
		#1 chk({saver_dark, wake_lockout, touch_out}, 3'b010);
		u_bsd_operator_model.press(-1, 0);
		u_bsd_operator_model.press(-1, 1);
		repeat (2) @(posedge pclk);
		#1 chk(touch_out, 0);
		u_bsd_operator_model.press(-1, 0);
		for (n = 0; n < 200 && wake_lockout !== 1'b0; n++) @(posedge pclk);
		u_bsd_operator_model.press(-1, 1);
		repeat (2) @(posedge pclk);
		#1 chk(touch_out, 1);
		u_bsd_operator_model.press(-1, 0);
		apb(0, 8'h10, 0);
		chk(r, 2);
		$display("test touch wake done");
		for (n = 0; n < 200 && saver_dark !== 1'b1; n++) @(posedge pclk);
		u_bsd_operator_model.press(2, 1);
		repeat (2) @(posedge pclk);
		#1 chk({saver_dark, wake_lockout, key_out}, 6'b010000);
		u_bsd_operator_model.press(2, 0);
		$display("test key wake done");
		// reset in the middle of a lockout
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		#1 chk({pready, pslverr, touch_out, key_out}, 0);
		chk({backlight_pwm, saver_dark, wake_lockout}, 0);
		chk(prdata, 0);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(0, 8'h00, 0);
		chk(r, 32'h00000064);
		apb(0, 8'h0C, 0);
		chk(r, 32'h00000001);
		$display("test reset mid-run done");
		repeat (40) @(posedge pclk);
		u_bsd_operator_model.press(1, 1);
		repeat (2) @(posedge pclk);
		#1 chk(key_out, 4'b0010);
		u_bsd_operator_model.press(1, 0);
		apb(0, 8'h14, 0);
		chk(r <= 2, 1);
		$display("test key accept done");
		tally_and_finish();
	end
endmodule : bsd_backlight_saver_test
